// [rate_gen_map.svh]
/*
 * register offsets, field positions, reset values and prescale counts
 * for the serial port rate generator; included by the rtl and the testbench.
 */
`ifndef RATE_GEN_MAP_SVH
`define RATE_GEN_MAP_SVH

// register offsets on the plain register port
`define OFS_TX_CTRL 3'h0
`define OFS_RX_CTRL 3'h1
`define OFS_BAUD_CTRL 3'h2
`define OFS_DIV_HI 3'h3
`define OFS_DIV_LO 3'h4
`define OFS_STATUS 3'h5

// field positions
`define TX_SYNC_BIT 4
`define TX_MASTER_BIT 7
`define TX_HIGH_SPEED_BIT 2
`define RX_ENABLE_BIT 7
`define BAUD_WIDE_BIT 3

// reset values
`define TX_CTRL_RST 8'h02
`define RX_CTRL_RST 8'h00
`define BAUD_CTRL_RST 8'h40
`define DIV_RST 8'h00

// prescale counts minus one: clocks per counter step of 64, 16 and 4
`define PRE_DIV64 6'h3f
`define PRE_DIV16 6'h0f
`define PRE_DIV4 6'h03

`endif

// [rate_gen_pkg.sv]
/*
 * types shared by the rate generator; constants live in rate_gen_map.svh.
 */
package rate_gen_pkg;
	// control fields gathered from the transmit and baud control registers
	typedef struct packed {
		logic sync_mode;
		logic master;
		logic high_speed;
		logic wide;
	} rate_cfg_t;

	// register port request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// [rate_gen.sv]
/*
 * rate generator: prescaler plus down counter making one tick per bit
 * period in every mode but sync slave, a sample strobe at the counter clock and a three
 * sample majority filter on the receive pin.
 * assumes inputs synchronous to clk_sys and a register master that never
 * waits; read data valid the cycle after the read strobe.
 */
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "rate_gen_map.svh"

// How it works
// - counter uses an 8-bit divisor after reset, 16-bit when wide select set
// - wide select is baud control bit 3, high speed is transmit control bit 2
// - high:low divisor sets a free-running timer period for async and sync
// - sync ignores high speed; async uses both high speed and wide select
// - sync rates apply only as clock master, slave timing comes from outside; async runs either way
// - async, 8-bit, low speed gives clock over 64 times n plus one
// - async 8-bit high or 16-bit low gives clock over 16 times n plus one
// - async 16-bit high, or sync, gives clock over 4 times n plus one
// - writing either divisor byte clears the counter at once
// - receive pin sampled three times, level decided by majority vote
module rate_gen
	import rate_gen_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic receive_pin,
	output logic receive_level,
	output logic sample_tick,
	output logic rate_tick
);

	reg_req_t req;
	rate_cfg_t cfg;
	logic [7:0] tx_ctrl_q, rx_ctrl_q, baud_ctrl_q;
	logic [7:0] div_hi_q, div_lo_q;
	logic [7:0] rdata_d;
	logic [15:0] div_n;
	logic [15:0] cnt_q;
	logic [5:0] pre_q, pre_max;
	logic pre_tick, div_wr, run;
	logic [2:0] samp_q;
	logic level_q;
	logic tick_q, samp_tick_q;
	logic cfg_wr;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// control fields out of the registers
	assign cfg.sync_mode = tx_ctrl_q[`TX_SYNC_BIT];
	assign cfg.master = tx_ctrl_q[`TX_MASTER_BIT];
	assign cfg.high_speed = tx_ctrl_q[`TX_HIGH_SPEED_BIT];
	assign cfg.wide = baud_ctrl_q[`BAUD_WIDE_BIT];

	// generator runs while the port is on, and in sync only as master
	assign run = rx_ctrl_q[`RX_ENABLE_BIT] & (~cfg.sync_mode | cfg.master);

	// register writes; only writable bits stored
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_ctrl_q <= `TX_CTRL_RST;
			rx_ctrl_q <= `RX_CTRL_RST;
			baud_ctrl_q <= `BAUD_CTRL_RST;
			div_hi_q <= `DIV_RST;
			div_lo_q <= `DIV_RST;
		end else if (req.wr) begin
			unique case (req.addr)
				`OFS_TX_CTRL: tx_ctrl_q <= {req.wdata[7:2], 1'b1, req.wdata[0]};
				`OFS_RX_CTRL: rx_ctrl_q <= {req.wdata[7:3], 3'h0};
				`OFS_BAUD_CTRL: baud_ctrl_q <= {2'h1, req.wdata[5:4],
					req.wdata[3], 1'b0, req.wdata[1:0]};
				`OFS_DIV_HI: div_hi_q <= req.wdata;
				`OFS_DIV_LO: div_lo_q <= req.wdata;
				default: ;
			endcase
		end
	end

	// read mux; status word shows the generator's live state
	always_comb begin
		rdata_d = 8'h00;
		unique case (req.addr)
			`OFS_TX_CTRL: rdata_d = tx_ctrl_q;
			`OFS_RX_CTRL: rdata_d = rx_ctrl_q;
			`OFS_BAUD_CTRL: rdata_d = baud_ctrl_q;
			`OFS_DIV_HI: rdata_d = div_hi_q;
			`OFS_DIV_LO: rdata_d = div_lo_q;
			`OFS_STATUS: rdata_d = {4'h0, run, level_q, cfg.wide,
				cnt_q == 16'h0000};
			default: rdata_d = 8'h00;
		endcase
	end

	// read data held one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= req.rd ? rdata_d : 8'h00;
		end
	end

	// high byte ignored in narrow mode
	assign div_n = cfg.wide ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
	assign div_wr = req.wr & (req.addr == `OFS_DIV_HI | req.addr == `OFS_DIV_LO);

	// prescale: async narrow low = 64, async narrow high or wide low = 16,
	// async wide high and all sync = 4; the whole 64, 16 or 4 factor lives here,
	// so the counter output is the bit-rate tick with no further divide
	always_comb begin
		if (cfg.sync_mode) begin
			pre_max = `PRE_DIV4;
		end else if (!cfg.wide && !cfg.high_speed) begin
			pre_max = `PRE_DIV64;
		end else if (cfg.wide && cfg.high_speed) begin
			pre_max = `PRE_DIV4;
		end else begin
			pre_max = `PRE_DIV16;
		end
	end

	// prescaler is cleared with the counter so a new divisor acts at once
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || !run) begin
			pre_q <= 6'h00;
		end else if (pre_q >= pre_max) begin
			pre_q <= 6'h00;
		end else begin
			pre_q <= pre_q + 6'h01;
		end
	end
	assign pre_tick = run & ~div_wr & (pre_q >= pre_max);

	// free-running down counter, reload from n at zero
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || !run) begin
			cnt_q <= 16'h0000;
		end else if (pre_tick) begin
			cnt_q <= (cnt_q == 16'h0000) ? div_n : cnt_q - 16'h0001;
		end
	end

	// tick at reload; registered so the outputs come from flops
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || !run) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= pre_tick & (cnt_q == 16'h0000);
		end
	end

	// one rate tick per bit period in every mode but sync slave; the 64, 16 and 4 of
	// the rate formulas sit in the prescaler, so no sub-divider is needed
	// and the shift logic outside moves one bit per tick
	assign rate_tick = tick_q;

	// sample strobe at the prescaled counter clock; gives the receive
	// filter many samples per bit without a second divider
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || !run) begin
			samp_tick_q <= 1'b0;
		end else begin
			samp_tick_q <= pre_tick;
		end
	end
	assign sample_tick = samp_tick_q;

	// three samples per decision; a single glitch cannot flip the level
	// as long as it lasts no longer than one sample strobe period
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			samp_q <= 3'h7;
			level_q <= 1'b1;
		end else begin
			if (samp_tick_q) begin
				samp_q <= {samp_q[1:0], receive_pin};
			end
			level_q <= (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2])
				| (samp_q[0] & samp_q[2]);
		end
	end
	assign receive_level = level_q;

	// writes that change the divide factor without clearing the counter;
	// the period in flight at such a write is a mix of old and new
	assign cfg_wr = req.wr & (req.addr == `OFS_TX_CTRL
		| req.addr == `OFS_BAUD_CTRL);

	// assertion helpers: clocks since the last rate tick and since the
	// last sample strobe; a period is judged only once a whole one has
	// passed under one setting, since a write may cut the one in flight
	logic [23:0] gap_q;
	logic [5:0] sgap_q;
	logic seen_q, sseen_q;

	// rate tick spacing, counted from one after each tick
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || !run || tick_q) begin
			gap_q <= 24'h1;
		end else begin
			gap_q <= gap_q + 24'h1;
		end
	end

	// a rate tick seen since the last restart or setting change
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || cfg_wr || !run) begin
			seen_q <= 1'b0;
		end else if (tick_q) begin
			seen_q <= 1'b1;
		end
	end

	// sample strobe spacing, counted from one after each strobe
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || !run || samp_tick_q) begin
			sgap_q <= 6'h01;
		end else begin
			sgap_q <= sgap_q + 6'h01;
		end
	end

	// a sample strobe seen since the last restart or setting change
	always_ff @(posedge clk_sys) begin
		if (rst || div_wr || cfg_wr || !run) begin
			sseen_q <= 1'b0;
		end else if (samp_tick_q) begin
			sseen_q <= 1'b1;
		end
	end

	sequence s_div_write;
		div_wr;
	endsequence

	sequence s_cleared;
		cnt_q == 16'h0000 && pre_q == 6'h00;
	endsequence

	// a tick that closes a whole period under one setting
	sequence s_rate_tick_seen;
		tick_q && $past(seen_q);
	endsequence

	// a strobe that closes a whole prescale under one setting
	sequence s_samp_tick_seen;
		samp_tick_q && $past(sseen_q);
	endsequence

	a_write_clears: assert property (@(posedge clk_sys) disable iff (rst)
		s_div_write |=> s_cleared)
		else $error("divisor write did not clear counter");

	a_narrow_ignores_hi: assert property (@(posedge clk_sys) disable iff (rst)
		!cfg.wide |-> div_n[15:8] == 8'h00)
		else $error("high byte used in narrow mode");

	a_reload_value: assert property (@(posedge clk_sys) disable iff (rst)
		(run && !div_wr && pre_tick && cnt_q == 16'h0000) ##1 !div_wr
		|-> cnt_q == $past(div_n))
		else $error("counter did not reload from divisor");

	a_tick_period: assert property (@(posedge clk_sys) disable iff (rst)
		s_rate_tick_seen |->
		$past(gap_q) + 24'h1 == ({8'h00, $past(div_n)} + 24'h1)
		* ({18'h0, $past(pre_max)} + 24'h1))
		else $error("tick period wrong");

	a_sample_period: assert property (@(posedge clk_sys) disable iff (rst)
		s_samp_tick_seen |-> $past(sgap_q) == $past(pre_max))
		else $error("sample strobe period wrong");

	a_tick_at_zero: assert property (@(posedge clk_sys) disable iff (rst)
		tick_q |-> $past(cnt_q) == 16'h0000)
		else $error("tick away from terminal count");

	a_tick_single: assert property (@(posedge clk_sys) disable iff (rst)
		tick_q |=> !tick_q)
		else $error("rate tick longer than one clock");

	a_reset_narrow: assert property (@(posedge clk_sys)
		rst |=> !cfg.wide)
		else $error("wide select set after reset");

	a_idle_still: assert property (@(posedge clk_sys) disable iff (rst)
		!run |=> !tick_q && !samp_tick_q)
		else $error("ticks while generator stopped");

	a_sync_div4: assert property (@(posedge clk_sys) disable iff (rst)
		cfg.sync_mode |-> pre_max == `PRE_DIV4)
		else $error("sync mode prescale wrong");

	a_async_slow: assert property (@(posedge clk_sys) disable iff (rst)
		(!cfg.sync_mode && !cfg.wide && !cfg.high_speed) |-> pre_max == `PRE_DIV64)
		else $error("async narrow low prescale wrong");

	a_async_mid: assert property (@(posedge clk_sys) disable iff (rst)
		(!cfg.sync_mode && (cfg.wide ^ cfg.high_speed)) |-> pre_max == `PRE_DIV16)
		else $error("async mid prescale wrong");

	a_async_fast: assert property (@(posedge clk_sys) disable iff (rst)
		(!cfg.sync_mode && cfg.wide && cfg.high_speed) |-> pre_max == `PRE_DIV4)
		else $error("async wide high prescale wrong");

	a_slave_still: assert property (@(posedge clk_sys) disable iff (rst)
		(cfg.sync_mode && !cfg.master) [*2] |-> !tick_q && cnt_q == 16'h0000)
		else $error("generator running as slave");

	a_majority: assert property (@(posedge clk_sys) disable iff (rst)
		(samp_q == 3'h3 || samp_q == 3'h5 || samp_q == 3'h6) |=> level_q)
		else $error("majority vote wrong");

	a_minority: assert property (@(posedge clk_sys) disable iff (rst)
		(samp_q == 3'h1 || samp_q == 3'h2 || samp_q == 3'h4) |=> !level_q)
		else $error("minority vote wrong");

endmodule

`default_nettype wire

// [tb_rate_gen.sv]
/*
 * self-checking bench for rate_gen: register port, tick periods per mode,
 * divisor restart, slave silence and the receive majority filter.
 * assumes rate_gen_map.svh offsets and a 40 MHz clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rate_gen_map.svh"
module tb_rate_gen;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic receive_pin = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic receive_level;
	logic sample_tick;
	logic rate_tick;
	logic [7:0] d;
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int c;

	always #12.5 clk_sys = ~clk_sys;

	rate_gen i_rate_gen (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .receive_pin(receive_pin),
		.receive_level(receive_level), .sample_tick(sample_tick),
		.rate_tick(rate_tick));

	task check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard: whole run is well under this many cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			close_out();
		end
	end

	// tasks are entered just after a rising edge; the 1 ns step keeps a
	// strobe from being lowered and raised in one time step
	task wr(input logic [2:0] a, input logic [7:0] v);
		#1;
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe edge
	task rd(input logic [2:0] a, output logic [7:0] v);
		#1;
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask

	// edges until the chosen tick is seen, capped at 2000; looked at
	// 1 ns after each edge so the flops have settled
	task count(input logic which, output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1;
			n++;
		end while ((which ? rate_tick : sample_tick) !== 1'b1 && n < 2000);
	endtask

	task t_regs;
		logic [7:0] rst_val [5];
		rst_val = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00};
		for (int i = 0; i < 5; i++) begin
			rd(3'(i), d);
			check("reset value", d, rst_val[i]);
		end
		rd(`OFS_STATUS, d);
		check("status narrow", d & 8'h0e, 8'h04);
		wr(3'h6, 8'hff);
		rd(3'h6, d);
		check("unmapped", d, 8'h00);
		wr(`OFS_BAUD_CTRL, 8'hff);
		rd(`OFS_BAUD_CTRL, d);
		check("baud ro bits", d, 8'h7b);
		rd(`OFS_STATUS, d);
		check("status wide", d & 8'h02, 8'h02);
		$display("register test done");
	endtask

	// divisor low byte written last so the restart is measured from it;
	// n is the divisor in use and p the prescale the mode selects, so a
	// cleared counter ticks after p clocks and then every (n + 1) * p
	task t_mode(input logic [7:0] tx, input logic [7:0] bc,
		input logic [7:0] hi, input logic [7:0] lo, input int n,
		input int p);
		wr(`OFS_TX_CTRL, tx);
		wr(`OFS_BAUD_CTRL, bc);
		wr(`OFS_DIV_HI, hi);
		wr(`OFS_DIV_LO, lo);
		count(1'b1, c);
		check("restart", 16'(c), 16'(p));
		count(1'b1, c);
		check("rate period", 16'(c), 16'((n + 1) * p));
		count(1'b0, c);
		check("sample period", 16'(c), 16'(p));
		$display("mode test done tx %h baud %h", tx, bc);
	endtask

	task t_slave;
		wr(`OFS_TX_CTRL, 8'h10);
		wr(`OFS_DIV_LO, 8'h04);
		count(1'b0, c);
		check("slave silent", 16'(c), 16'd2000);
		count(1'b1, c);
		check("slave no rate", 16'(c), 16'd2000);
		$display("slave test done");
	endtask

	// strobes every 4 clocks, so a 1-clock glitch is sampled once at most
	task t_major;
		t_mode(8'h04, 8'h08, 8'h00, 8'h02, 2, 4);
		receive_pin <= 1'b0;
		repeat (12) @(posedge clk_sys);
		#1;
		check("level low", receive_level, 1'b0);
		receive_pin <= 1'b1;
		@(posedge clk_sys);
		receive_pin <= 1'b0;
		repeat (12) @(posedge clk_sys);
		#1;
		check("glitch filtered", receive_level, 1'b0);
		receive_pin <= 1'b1;
		repeat (12) @(posedge clk_sys);
		#1;
		check("level high", receive_level, 1'b1);
		$display("majority test done");
	endtask

	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		wr(`OFS_RX_CTRL, 8'h80);
		t_mode(8'h00, 8'h00, 8'h01, 8'h02, 2, 64);
		t_mode(8'h00, 8'h00, 8'h00, 8'h00, 0, 64);
		t_mode(8'h04, 8'h00, 8'h00, 8'h05, 5, 16);
		t_mode(8'h00, 8'h08, 8'h00, 8'h03, 3, 16);
		t_mode(8'h04, 8'h08, 8'h01, 8'h00, 256, 4);
		t_mode(8'h94, 8'h00, 8'h01, 8'h04, 4, 4);
		t_mode(8'h90, 8'h08, 8'h00, 8'h07, 7, 4);
		t_slave();
		t_major();
		close_out();
	end
endmodule
`default_nettype wire
